/* File: src/input_capture_defines.vh */
`ifndef INPUT_CAPTURE_DEFINES_VH
`define INPUT_CAPTURE_DEFINES_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define OFS_CONTROL      4'h0
`define OFS_BUFFER       4'h4
`define OFS_IRQ_STATUS   4'h8
`define OFS_IRQ_MASK     4'hc

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define BIT_STOP_IN_IDLE 13
`define BIT_TIMER_SELECT 7
`define BIT_PER_IRQ_HI   6
`define BIT_PER_IRQ_LO   5
`define BIT_OVERFLOW     4
`define BIT_NOT_EMPTY    3
`define BIT_MODE_HI      2
`define BIT_MODE_LO      0

// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define IRQ_CAPTURE      0
`define IRQ_OVERFLOW     1
`define IRQ_WAKE         2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CONTROL      16'h0000
`define RST_MASK         3'h0

// ----------------------------------------
// Capture mode codes
// ----------------------------------------
`define MODE_OFF         3'h0
`define MODE_EVERY_EDGE  3'h1
`define MODE_FALL        3'h2
`define MODE_RISE        3'h3
`define MODE_RISE_4      3'h4
`define MODE_RISE_16     3'h5
`define MODE_UNUSED      3'h6
`define MODE_WAKE_PIN    3'h7

// ----------------------------------------
// Prescaler terminal counts and buffer size
// ----------------------------------------
`define PRESCALE_4_LAST  4'h3
`define PRESCALE_16_LAST 4'hf
`define FIFO_DEPTH       4
`define FIFO_PTR_W       2

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

/* File: src/edge_prescaler.v */
`timescale 1ns/1ps
`include "input_capture_defines.vh"

module edge_prescaler
(
   input  wire       aclk,
   input  wire       aresetn,
   input  wire       clear,
   input  wire       enable,
   input  wire [2:0] mode,
   input  wire       rise,
   input  wire       fall,
   output reg        capture
);

   reg  [3:0] count_reg;
   reg  [3:0] count_next;
   reg  [3:0] last;
   reg        counted;

   // Select the edges that count and the prescaler terminal value
   always @*
   begin
      capture = 1'b0;
      counted = 1'b0;
      last = 4'h0;
      count_next = count_reg;
      if (enable)
      begin
         case (mode)
            `MODE_EVERY_EDGE: capture = rise | fall;
            `MODE_FALL:       capture = fall;
            `MODE_RISE:       capture = rise;
            `MODE_RISE_4:
            begin
               counted = 1'b1;
               last = `PRESCALE_4_LAST;
            end
            `MODE_RISE_16:
            begin
               counted = 1'b1;
               last = `PRESCALE_16_LAST;
            end
            default: capture = 1'b0;
         endcase
      end
      if (counted && rise)
      begin
         if (count_reg == last)
         begin
            capture = 1'b1;
            count_next = 4'h0;
         end
         else
         begin
            count_next = count_reg + 4'h1;
         end
      end
      if (clear)
      begin
         count_next = 4'h0;
      end
   end

   // Prescaler counter restarts when the mode is rewritten
   always @(posedge aclk)
   begin
      if (!aresetn)
         count_reg <= 4'h0;
      else
         count_reg <= count_next;
   end

endmodule

/* File: src/capture_fifo.v */
`timescale 1ns/1ps
`include "input_capture_defines.vh"

module capture_fifo
(
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        push,
   input  wire [15:0] push_data,
   input  wire        pop,
   output wire [15:0] head,
   output wire        full,
   output wire        empty
);

   reg  [15:0]          mem_reg [0:`FIFO_DEPTH-1];
   reg  [`FIFO_PTR_W-1:0] wr_ptr_reg;
   reg  [`FIFO_PTR_W-1:0] rd_ptr_reg;
   reg  [`FIFO_PTR_W:0]   level_reg;
   wire                   do_push;
   wire                   do_pop;

   // Push into a full buffer is dropped; caller flags overflow
   assign do_push = push & ~full;
   assign do_pop  = pop & ~empty;
   assign full    = (level_reg == `FIFO_DEPTH);
   assign empty   = (level_reg == 0);
   assign head    = mem_reg[rd_ptr_reg];

   // Pointer and occupancy bookkeeping
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wr_ptr_reg <= {`FIFO_PTR_W{1'b0}};
         rd_ptr_reg <= {`FIFO_PTR_W{1'b0}};
         level_reg  <= {(`FIFO_PTR_W+1){1'b0}};
      end
      else
      begin
         if (do_push)
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (do_pop)
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         if (do_push && !do_pop)
            level_reg <= level_reg + 1'b1;
         else if (do_pop && !do_push)
            level_reg <= level_reg - 1'b1;
      end
   end

   // Storage has no reset; empty guards every read
   always @(posedge aclk)
   begin
      if (do_push)
         mem_reg[wr_ptr_reg] <= push_data;
   end

endmodule

/* File: src/input_capture_channel.v */
`timescale 1ns/1ps
`include "input_capture_defines.vh"

module input_capture_channel
(
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        capture_pin,
   input  wire [15:0] timer_two_count,
   input  wire [15:0] timer_three_count,
   input  wire        cpu_idle,
   input  wire        cpu_sleep,
   output reg         irq
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------

   // Codes that take part in timed capture
   function capture_mode;
      input [2:0] m;
      begin
         capture_mode = (m != `MODE_OFF) && (m != `MODE_UNUSED)
                        && (m != `MODE_WAKE_PIN);
      end
   endfunction

   // Expand byte strobes over the low half-word
   function [15:0] lane_mask;
      input [3:0] strb;
      begin
         lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
      end
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   reg  [15:0] control_reg;
   reg  [2:0]  status_reg;
   reg  [2:0]  status_next;
   reg  [2:0]  mask_reg;
   reg         overflow_reg;
   reg         overflow_next;
   reg  [1:0]  irq_count_reg;
   reg  [1:0]  irq_count_next;
   reg         pin_meta_reg;
   reg         pin_sync_reg;
   reg         pin_last_reg;
   reg  [3:0]  awaddr_reg;
   reg         aw_held_reg;
   reg  [15:0] wdata_reg;
   reg  [3:0]  wstrb_reg;
   reg         w_held_reg;
   reg  [31:0] rdata_next;
   reg  [1:0]  rresp_next;
   reg         pop_next;
   reg  [2:0]  status_clear;
   wire        rise;
   wire        fall;
   wire [2:0]  mode;
   wire        halted;
   wire        active;
   wire        capture_event;
   wire [15:0] captured_value;
   wire [15:0] fifo_head;
   wire        fifo_full;
   wire        fifo_empty;
   wire        do_write;
   wire        do_read;
   wire        ctrl_write;
   wire        capture_irq;
   wire        wake_event;

   // ----------------------------------------
   // Pin synchroniser and edge detection
   // ----------------------------------------

   // Two flops before any logic looks at the pin
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
         pin_last_reg <= 1'b0;
      end
      else
      begin
         pin_meta_reg <= capture_pin;
         pin_sync_reg <= pin_meta_reg;
         pin_last_reg <= pin_sync_reg;
      end
   end

   assign rise = pin_sync_reg & ~pin_last_reg;
   assign fall = ~pin_sync_reg & pin_last_reg;

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   assign mode   = control_reg[`BIT_MODE_HI:`BIT_MODE_LO];
   assign halted = control_reg[`BIT_STOP_IN_IDLE] & cpu_idle;
   assign active = capture_mode(mode) & ~halted;

   // Wake pin ignores every other control field
   assign wake_event = (mode == `MODE_WAKE_PIN) & (cpu_sleep | cpu_idle)
                       & rise;

   // Timer two on select high, timer three otherwise
   assign captured_value = control_reg[`BIT_TIMER_SELECT] ? timer_two_count
                           : timer_three_count;

   edge_prescaler u_prescaler
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clear   (ctrl_write),
      .enable  (active),
      .mode    (mode),
      .rise    (rise),
      .fall    (fall),
      .capture (capture_event)
   );

   capture_fifo u_fifo
   (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .push      (capture_event),
      .push_data (captured_value),
      .pop       (pop_next),
      .head      (fifo_head),
      .full      (fifo_full),
      .empty     (fifo_empty)
   );

   // ----------------------------------------
   // Captures per interrupt
   // ----------------------------------------

   // Count captures; restart on every interrupting one
   always @*
   begin
      irq_count_next = irq_count_reg;
      if (capture_irq)
         irq_count_next = 2'h0;
      else if (capture_event)
         irq_count_next = irq_count_reg + 2'h1;
      if (ctrl_write || !active)
         irq_count_next = 2'h0;
   end

   assign capture_irq = capture_event &
      ((mode == `MODE_EVERY_EDGE) ||
       (irq_count_reg == control_reg[`BIT_PER_IRQ_HI:`BIT_PER_IRQ_LO]));

   // ----------------------------------------
   // Overflow flag
   // ----------------------------------------

   // Set on capture into full buffer; cleared by any buffer pop without a capture in the same cycle
   always @*
   begin
      overflow_next = overflow_reg;
      if (pop_next && !capture_event)
         overflow_next = 1'b0;
      if (capture_event && fifo_full)
         overflow_next = 1'b1;
   end

   // ----------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------
   assign do_write   = aw_held_reg & w_held_reg & ~s_axi_bvalid;
   assign ctrl_write = do_write & (awaddr_reg == `OFS_CONTROL);

   // Address and data are taken in either order and held
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         aw_held_reg   <= 1'b0;
         w_held_reg    <= 1'b0;
         awaddr_reg    <= 4'h0;
         wdata_reg     <= 16'h0000;
         wstrb_reg     <= 4'h0;
      end
      else
      begin
         s_axi_awready <= ~aw_held_reg & ~(s_axi_awvalid & s_axi_awready);
         s_axi_wready  <= ~w_held_reg & ~(s_axi_wvalid & s_axi_wready);
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata[15:0];
            wstrb_reg  <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // Every aligned word is mapped; read-only targets still answer OKAY
            s_axi_bresp  <= (awaddr_reg[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Register updates from software; flag bits stay hardware owned
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         control_reg <= `RST_CONTROL;
         mask_reg    <= `RST_MASK;
      end
      else if (do_write)
      begin
         if (awaddr_reg == `OFS_CONTROL)
            control_reg <= (control_reg & ~lane_mask(wstrb_reg)) |
                           (wdata_reg & lane_mask(wstrb_reg) &
                            16'h20e7);
         if (awaddr_reg == `OFS_IRQ_MASK && wstrb_reg[0])
            mask_reg <= wdata_reg[2:0];
      end
   end

   // ----------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------
   assign do_read = s_axi_arvalid & s_axi_arready;

   // Read data and read side effects
   always @*
   begin
      rdata_next   = 32'h00000000;
      rresp_next   = `RESP_OKAY;
      pop_next     = 1'b0;
      status_clear = 3'h0;
      if (do_read)
      begin
         case (s_axi_araddr)
            `OFS_CONTROL:
            begin
               rdata_next[15:0] = control_reg;
               rdata_next[`BIT_OVERFLOW]  = overflow_reg;
               rdata_next[`BIT_NOT_EMPTY] = ~fifo_empty;
            end
            `OFS_BUFFER:
            begin
               if (!fifo_empty)
               begin
                  rdata_next[15:0] = fifo_head;
                  pop_next = 1'b1;
               end
            end
            `OFS_IRQ_STATUS:
            begin
               rdata_next[2:0] = status_reg;
               status_clear = 3'h7;
            end
            `OFS_IRQ_MASK: rdata_next[2:0] = mask_reg;
            default: rresp_next = `RESP_SLVERR;
         endcase
      end
   end

   // One read in flight; arready drops until the data is taken
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= ~do_read & (~s_axi_rvalid | s_axi_rready); // Closed while answering
         if (do_read)
         begin
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rdata_next;
            s_axi_rresp   <= rresp_next;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid  <= 1'b0;
      end
   end

   // ----------------------------------------
   // Interrupt status, mask and output
   // ----------------------------------------

   // A new event beats the clear-on-read in the same cycle
   always @*
   begin
      status_next = status_reg & ~status_clear;
      if (capture_irq)
         status_next[`IRQ_CAPTURE] = 1'b1;
      if (capture_event && fifo_full)
         status_next[`IRQ_OVERFLOW] = 1'b1;
      if (wake_event)
         status_next[`IRQ_WAKE] = 1'b1;
   end

   // Flag, counter and status flops; irq updates in the same cycle as status
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         overflow_reg  <= 1'b0;
         irq_count_reg <= 2'h0;
         status_reg    <= 3'h0;
         irq           <= 1'b0;
      end
      else
      begin
         overflow_reg  <= overflow_next;
         irq_count_reg <= irq_count_next;
         status_reg    <= status_next;
         irq           <= |(status_next & mask_reg);
      end
   end

endmodule

/* File: tb/input_capture_channel_chk.sv */
`timescale 1ns/1ps
`include "input_capture_defines.vh"
module input_capture_channel_chk
(
   input wire        aclk,
   input wire        aresetn,
   input wire [3:0]  s_axi_awaddr,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [3:0]  s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready
);
   // ----------------------------------------
   // Helper and properties
   // ----------------------------------------
   reg [3:0] rd_addr_reg;
   wire      wr_take;
   wire      rd_take;
   assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign rd_take = s_axi_arvalid && s_axi_arready;
   // Remember the target of the read in flight
   always @(posedge aclk)
   begin
      if (!aresetn)
         rd_addr_reg <= 4'h0;
      else if (rd_take)
         rd_addr_reg <= s_axi_araddr;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
   property p_r_answer;
      rd_take |=> s_axi_rvalid;
   endproperty
   a_r_answer: assert property (p_r_answer) else $error("read answer late");
   property p_ar_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_block: assert property (p_ar_block) else $error("address taken during read");
   property p_ar_back;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready;
   endproperty
   a_ar_back: assert property (p_ar_back) else $error("read address not reopened");
   property p_w_answer;
      wr_take |-> ##2 s_axi_bvalid;
   endproperty
   a_w_answer: assert property (p_w_answer) else $error("write answer late");
   property p_w_err;
      wr_take && s_axi_awaddr[1:0] != 2'h0 |-> ##2 s_axi_bresp == `RESP_SLVERR;
   endproperty
   a_w_err: assert property (p_w_err) else $error("bad write address accepted");
   property p_r_err;
      rd_take && s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == `RESP_SLVERR
         && s_axi_rdata == 32'h0;
   endproperty
   a_r_err: assert property (p_r_err) else $error("bad read address accepted");
   property p_ctl_bits;
      s_axi_rvalid && rd_addr_reg == `OFS_CONTROL |-> (!s_axi_rdata[4] || s_axi_rdata[3])
         && s_axi_rdata[31:14] == 18'h0 && s_axi_rdata[12:8] == 5'h0;
   endproperty
   a_ctl_bits: assert property (p_ctl_bits) else $error("control flags wrong");
endmodule
bind input_capture_channel input_capture_channel_chk chk (.*);

/* File: tb/pin_timer_model.sv */
`timescale 1ns/1ps
module pin_timer_model
(
   input  wire        aclk,
   input  wire        pin_level,
   input  wire [15:0] t2_in,
   input  wire [15:0] t3_in,
   output reg         capture_pin,
   output reg  [15:0] timer_two_count,
   output reg  [15:0] timer_three_count
);
   // Timers hold between loads so that each capture has one right value
   always @(posedge aclk)
   begin
      capture_pin       <= pin_level;
      timer_two_count   <= t2_in;
      timer_three_count <= t3_in;
   end
endmodule

/* File: tb/input_capture_channel_tb_top.sv */
`timescale 1ns/1ps
module input_capture_channel_tb_top;
   reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   reg         s_axi_arvalid, s_axi_rready, cpu_idle, cpu_sleep, pin_level, ts;
   reg  [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   reg  [31:0] s_axi_wdata, r;
   reg  [15:0] t2_in, t3_in, ctl;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire        s_axi_rvalid, irq, capture_pin;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [15:0] timer_two_count, timer_three_count;
   reg  [33:0] rq[$], bq[$];
   integer     bad_count, total_checks, i, k;
   localparam [31:0] MODES = 32'h36054123;
   localparam [63:0] PULSES = 64'h0202021004020202;
   localparam [31:0] CAPS = 32'h00011422;
   localparam [7:0]  IDLE = 8'h82;
   localparam [7:0]  STOP = 8'h80;
   input_capture_channel uut (.*);
   pin_timer_model model (.*);
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task give_verdict;
      begin
         $display("checks %0d errors %0d", total_checks, bad_count);
         if (bad_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task cmp(input [33:0] e, input [33:0] g);
      begin
         total_checks = total_checks + 1;
         if (g !== e)
         begin
            bad_count = bad_count + 1;
            $display("ERROR %0t got %h want %h", $time, g, e);
         end
      end
   endtask
   task axi_write(input [3:0] a, input [31:0] d, input [1:0] e);
      reg aok, wok;
      begin
         aok = 1'b0;
         wok = 1'b0;
         bq.push_back({e, 32'h0});
         @(posedge aclk);
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         do
         begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            aok = aok | s_axi_awready;
            wok = wok | s_axi_wready;
         end
         while (!(aok && wok));
         do @(posedge aclk); while (!s_axi_bvalid);
         s_axi_bready <= 1'b0;
      end
   endtask
   task axi_read(input [3:0] a, input [33:0] e);
      begin
         rq.push_back(e);
         @(posedge aclk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         do @(posedge aclk); while (!s_axi_arready);
         s_axi_arvalid <= 1'b0;
         do @(posedge aclk); while (!s_axi_rvalid);
         s_axi_rready <= 1'b0;
      end
   endtask
   // Pops n buffered captures, all expected to hold v
   task drain(input [3:0] n, input [15:0] v);
      repeat (n) axi_read(4'h4, {18'h0, v});
   endtask
   // Each pulse is four cycles high and four low, then the pipeline settles
   task pulse(input [7:0] n);
      begin
         repeat (n)
         begin
            @(posedge aclk) pin_level <= 1'b1;
            repeat (4) @(posedge aclk);
            pin_level <= 1'b0;
            repeat (3) @(posedge aclk);
         end
         repeat (8) @(posedge aclk);
      end
   endtask
   // Sampled one step after the edge so the registered output has landed
   task chk_irq(input e);
      begin
         #1;
         cmp({33'h0, e}, {33'h0, irq});
      end
   endtask
   // ----------------------------------------
   // Clock, scoreboard, watchdog, sequence
   // ----------------------------------------
   initial
   begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   // Every answer seen on the bus retires the oldest note
   always @(posedge aclk)
   begin
      if (s_axi_rvalid && s_axi_rready)
         cmp(rq.size() ? rq.pop_front() : 34'bx, {s_axi_rresp, s_axi_rdata});
      if (s_axi_bvalid && s_axi_bready)
         cmp(bq.size() ? bq.pop_front() : 34'bx, {s_axi_bresp, 32'h0});
   end
   initial
   begin
      repeat (20000) @(posedge aclk);
      bad_count = bad_count + 1;
      give_verdict;
   end
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h0;
      {s_axi_rready, cpu_idle, cpu_sleep, pin_level} = 4'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, t2_in, t3_in} = 72'h0;
      s_axi_wstrb = 4'hf;
      bad_count = 0;
      total_checks = 0;
      r = $urandom(32'ha104);
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      for (i = 0; i < 4; i = i + 1)
         axi_read(i[1:0] * 4'h4, 34'h0);
      axi_write(4'h2, 32'hffff, 2'h2);
      axi_read(4'h2, {2'h2, 32'h0});
      axi_write(4'h0, 32'hffff, 2'h0);
      axi_read(4'h0, 34'h20e7);
      // Every capture mode, with random timers and alternating timer choice
      for (i = 0; i < 8; i = i + 1)
      begin
         r = $urandom;
         ts = i[0];
         t2_in <= r[15:0];
         t3_in <= r[31:16];
         cpu_idle <= IDLE[i];
         ctl = {2'h0, STOP[i], 5'h0, ts, 4'h0, MODES[4*i+:3]};
         axi_write(4'h0, {16'h0, ctl}, 2'h0);
         pulse(PULSES[8*i+:8]);
         axi_read(4'h0, {18'h0, ctl | {12'h0, CAPS[4*i+:4] != 4'h0, 3'h0}});
         drain(CAPS[4*i+:4], ts ? t2_in : t3_in);
         axi_read(4'h4, 34'h0);
      end
      cpu_idle <= 1'b0;
      axi_read(4'h8, 34'h1);
      // Capture count per interrupt
      axi_write(4'hc, 32'h1, 2'h0);
      for (k = 0; k < 4; k = k + 1)
      begin
         axi_write(4'h0, k * 32 + 3, 2'h0);
         pulse(k[7:0]);
         chk_irq(1'b0);
         pulse(1);
         chk_irq(1'b1);
         axi_read(4'h8, 34'h1);
         repeat (2) @(posedge aclk);
         chk_irq(1'b0);
         drain(k[3:0] + 4'h1, t3_in);
      end
      axi_write(4'h0, 32'h61, 2'h0);
      pulse(1);
      chk_irq(1'b1);
      axi_read(4'h8, 34'h1);
      drain(2, t3_in);
      axi_write(4'hc, 32'h0, 2'h0);
      axi_write(4'h0, 32'h3, 2'h0);
      pulse(1);
      chk_irq(1'b0);
      axi_read(4'h8, 34'h1);
      drain(1, t3_in);
      // Overflow on a full buffer, cleared by reading
      pulse(5);
      axi_read(4'h0, 34'h1b);
      axi_read(4'h8, 34'h3);
      drain(4, t3_in);
      axi_write(4'h0, 32'h13, 2'h0);
      axi_read(4'h0, 34'h3);
      // Wake pin while asleep, none while neither asleep nor idle
      axi_write(4'hc, 32'h4, 2'h0);
      cpu_sleep <= 1'b1;
      axi_write(4'h0, 32'h7, 2'h0);
      pulse(1);
      chk_irq(1'b1);
      axi_read(4'h0, 34'h7);
      axi_read(4'h8, 34'h4);
      cpu_sleep <= 1'b0;
      pulse(1);
      axi_read(4'h8, 34'h0);
      give_verdict;
   end
endmodule
